// [verilog/rcsd_top.sv]
// top: wishbone register file and four software-driven event channels
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module rcsd_top
    import rcsd_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             WB_ERR_O,
    // producer side
    input  wire logic [3:0]  PRODUCER_SIG,
    input  wire logic [3:0]  PRODUCER_ON,
    // channel outputs to consumers
    output logic      [3:0]  CHAN_OUT,
    // general-purpose pins
    output logic      [3:0]  PIN_OUT,
    output logic      [3:0]  PIN_OE,
    output logic      [2:0]  PIN_LOCATION
);
    logic [3:0] soft_hold_bits_reg;
    logic [3:0] soft_pulse_bits_reg;
    logic [3:0] pin_en_reg;
    logic [2:0] location_reg;
    logic [3:0] producer_sel;
    logic       req;
    logic       hit;
    logic       wr_pulse;
    logic       wr_hold;
    logic       wr_route;
    logic [31:0] rdata_next;

    // a request is taken once; ack drops the cycle after so a held strobe is not taken twice
    // unmapped offsets answer with err, so a stray access never leaves the master waiting
    assign req      = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    assign hit      = (WB_ADR_I == RCSD_OFF_PULSE) || (WB_ADR_I == RCSD_OFF_HOLD) ||
                      (WB_ADR_I == RCSD_OFF_ROUTE);
    // only byte lane 0 and 1 hold bits; reserved bits from software are discarded
    assign wr_pulse = req && WB_WE_I && WB_ADR_I == RCSD_OFF_PULSE && WB_SEL_I[0];
    assign wr_hold  = req && WB_WE_I && WB_ADR_I == RCSD_OFF_HOLD  && WB_SEL_I[0];
    assign wr_route = req && WB_WE_I && WB_ADR_I == RCSD_OFF_ROUTE;

    // bus answer: one cycle after the request, err for unmapped offsets
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_ERR_O <= 1'b0;
        end else begin
            WB_ACK_O <= req && hit;
            WB_ERR_O <= req && !hit;
        end
    end

    // read mux; pulse register and reserved bits give zero
    always_comb begin
        rdata_next = RCSD_RDATA_RST;
        unique case (WB_ADR_I)
            RCSD_OFF_HOLD: begin
                rdata_next[3:0] = soft_hold_bits_reg;
            end
            RCSD_OFF_ROUTE: begin
                rdata_next[RCSD_PEN_LSB +: 4]          = pin_en_reg;
                rdata_next[RCSD_LOC_MSB:RCSD_LOC_LSB] = location_reg;
            end
            default: begin
                rdata_next = RCSD_RDATA_RST;
            end
        endcase
    end

    // read data stands only in the answer cycle and is zero otherwise, so no stale word leaks
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            WB_DAT_O <= RCSD_RDATA_RST;
        end else if (req && !WB_WE_I) begin
            WB_DAT_O <= rdata_next;
        end else begin
            WB_DAT_O <= RCSD_RDATA_RST;
        end
    end

    // held level bits keep their value until rewritten
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            soft_hold_bits_reg <= RCSD_HOLD_RST;
        end else if (wr_hold) begin
            soft_hold_bits_reg <= WB_DAT_I[3:0];
        end
    end

    // pulse bits live for the single cycle after the write, then clear themselves
    // ack blocks a retake in the next cycle, so a pulse can never stretch to two cycles
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            soft_pulse_bits_reg <= RCSD_PULSE_RST;
        end else if (wr_pulse) begin
            soft_pulse_bits_reg <= WB_DAT_I[3:0];
        end else begin
            soft_pulse_bits_reg <= 4'h0;
        end
    end

    // routing register: pin enables and location, byte lanes honoured
    // enables and location sit in different byte lanes, so either may be written alone
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pin_en_reg   <= RCSD_PEN_RST;
            location_reg <= RCSD_LOC_RST;
        end else if (wr_route) begin
            if (WB_SEL_I[0]) begin
                pin_en_reg <= WB_DAT_I[RCSD_PEN_LSB +: 4];
            end
            if (WB_SEL_I[1]) begin
                location_reg <= WB_DAT_I[RCSD_LOC_MSB:RCSD_LOC_LSB];
            end
        end
    end

    // location is forwarded to the pin mux outside; codes above 2 are passed unchanged
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PIN_LOCATION <= RCSD_LOC_RST;
        end else begin
            PIN_LOCATION <= location_reg;
        end
    end

    // producer selection off forces a zero input term
    assign producer_sel = PRODUCER_SIG & PRODUCER_ON;

    // one flop stage per channel keeps every block output straight from a register
    genvar g;
    generate
        for (g = 0; g < RCSD_CHANNELS; g = g + 1) begin : g_chan
            rcsd_chan u_chan (
                .clk         (CLK_SYS),
                .nrst        (NRST),
                .hold_bit    (soft_hold_bits_reg[g]),
                .pulse_bit   (soft_pulse_bits_reg[g]),
                .producer_in (producer_sel[g]),
                .pin_en      (pin_en_reg[g]),
                .chan_out    (CHAN_OUT[g]),
                .pin_out     (PIN_OUT[g]),
                .pin_oe      (PIN_OE[g])
            );
        end
    endgenerate

    // bus answer and read-back checks
    ack_hit_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        req && hit |=> WB_ACK_O && !WB_ERR_O)
        else $error("mapped access not acknowledged");
    err_unmap_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        req && !hit |=> WB_ERR_O && !WB_ACK_O)
        else $error("unmapped access not answered with err");
    ack_once_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        WB_ACK_O || WB_ERR_O |=> !WB_ACK_O && !WB_ERR_O)
        else $error("bus answer longer than one cycle");
    pulse_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        req && !WB_WE_I && WB_ADR_I == RCSD_OFF_PULSE |=> WB_ACK_O && WB_DAT_O == 32'h0)
        else $error("pulse register read is not zero");
    hold_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        req && !WB_WE_I && WB_ADR_I == RCSD_OFF_HOLD |=> WB_DAT_O == {28'h0, $past(soft_hold_bits_reg)})
        else $error("level register read is wrong");
    route_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        req && !WB_WE_I && WB_ADR_I == RCSD_OFF_ROUTE |=>
        WB_DAT_O == {21'h0, $past(location_reg), 4'h0, $past(pin_en_reg)})
        else $error("routing register read is wrong");
    rsv_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        WB_ACK_O |-> WB_DAT_O[31:11] == 21'h0 && WB_DAT_O[7:4] == 4'h0)
        else $error("reserved bits do not read zero");

    // register checks
    pulse_bits_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_pulse |=> soft_pulse_bits_reg == $past(WB_DAT_I[3:0]))
        else $error("pulse bits do not follow the written ones");
    pulse_one_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_pulse && WB_DAT_I[0] |=> soft_pulse_bits_reg[0] ##1 !soft_pulse_bits_reg[0])
        else $error("software pulse not exactly one cycle");
    pulse_zero_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !wr_pulse |=> soft_pulse_bits_reg == 4'h0)
        else $error("pulse without a write");
    hold_write_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_hold |=> soft_hold_bits_reg == $past(WB_DAT_I[3:0]))
        else $error("level bits do not take the written value");
    hold_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !wr_hold |=> $stable(soft_hold_bits_reg))
        else $error("level bits changed without a write");
    route_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !wr_route |=> $stable(pin_en_reg) && $stable(location_reg))
        else $error("routing fields changed without a write");
    route_wr_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_route && WB_SEL_I[0] |=> ##1 PIN_OE == $past(WB_DAT_I[3:0], 2))
        else $error("pin enables do not follow the routing write");
    loc_wr_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_route && WB_SEL_I[1] |=> ##1 PIN_LOCATION == $past(WB_DAT_I[10:8], 2))
        else $error("location does not follow the routing write");

    // channel path checks; outputs lag the registers by one flop
    // the producer term is taken one edge back, where the channel flop samples it
    pulse_out_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        wr_pulse && WB_DAT_I[0] |=> ##1 CHAN_OUT[0] != ($past(soft_hold_bits_reg[0]) ^ $past(producer_sel[0])))
        else $error("pulse does not invert the level on the channel output");
    off_prod_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        PRODUCER_ON == 4'h0 && soft_pulse_bits_reg == 4'h0 |=> CHAN_OUT == $past(soft_hold_bits_reg))
        else $error("off producer leaks into channel output");
endmodule

// [verilog/rcsd_pkg.sv]
// package: register map, field layout and reset values of the software channel drive block
package rcsd_pkg;
    localparam int          RCSD_CHANNELS      = 4;
    localparam int          RCSD_ADDR_W        = 4;
    // register byte offsets
    localparam logic [3:0]  RCSD_OFF_PULSE     = 4'h0;
    localparam logic [3:0]  RCSD_OFF_HOLD      = 4'h4;
    localparam logic [3:0]  RCSD_OFF_ROUTE     = 4'h8;
    // field positions
    localparam int          RCSD_PEN_LSB       = 0;
    localparam int          RCSD_LOC_LSB       = 8;
    localparam int          RCSD_LOC_MSB       = 10;
    // reset values
    localparam logic [3:0]  RCSD_HOLD_RST      = 4'h0;
    localparam logic [3:0]  RCSD_PULSE_RST     = 4'h0;
    localparam logic [3:0]  RCSD_PEN_RST       = 4'h0;
    localparam logic [2:0]  RCSD_LOC_RST       = 3'h0;
    localparam logic [31:0] RCSD_RDATA_RST     = 32'h0;
endpackage

// [verilog/rcsd_chan.sv]
// one channel: xor of held level, one-cycle pulse and producer input, registered
`timescale 1ns/100ps
module rcsd_chan (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // channel terms
    input  wire logic hold_bit,
    input  wire logic pulse_bit,
    input  wire logic producer_in,
    input  wire logic pin_en,
    // results
    output logic      chan_out,
    output logic      pin_out,
    output logic      pin_oe
);
    logic chan_next;

    // three-term combination, registered so the top output comes from a flop
    assign chan_next = hold_bit ^ pulse_bit ^ producer_in;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chan_out <= 1'b0;
            pin_out  <= 1'b0;
            pin_oe   <= 1'b0;
        end else begin
            chan_out <= chan_next;
            // a pin that is not driven stays low, so a disabled pin never shows channel activity
            pin_out  <= pin_en & chan_next;
            pin_oe   <= pin_en;
        end
    end

    chan_xor_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> chan_out == ($past(hold_bit) ^ $past(pulse_bit) ^ $past(producer_in)))
        else $error("channel output is not the xor of its three terms");
    pin_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        pin_oe |-> pin_out == chan_out)
        else $error("pin value differs from channel output");
    pin_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
        !pin_oe |-> !pin_out)
        else $error("pin shows activity while not enabled");
endmodule

// [bench/rcsd_prod_model.sv]
// producer-side model feeding the selected producer inputs of the block
`timescale 1ns/100ps
module rcsd_prod_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // requested producer activity
    input  wire logic [3:0] want_sig,
    input  wire logic [3:0] want_on,
    // to the block
    output logic      [3:0] sig,
    output logic      [3:0] on
);
    // an idle producer line wiggles every cycle, so a leak through an off channel shows
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sig <= 4'h0;
            on  <= 4'h0;
        end else begin
            on  <= want_on;
            sig <= (want_sig & want_on) | (~sig & ~want_on);
        end
    end
endmodule

// [bench/testbench.sv]
// self-checking bench for the software channel drive block
`timescale 1ns/100ps
module testbench;
    import rcsd_pkg::*;
    logic        CLK_SYS = 1'b0;
    logic        NRST    = 1'b0;
    logic        wb_req  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [3:0]  wb_adr  = 4'h0;
    logic [31:0] wb_dat  = 32'h0;
    logic [3:0]  wb_sel  = 4'hF;
    logic [3:0]  want_sig = 4'h0;
    logic [3:0]  want_on  = 4'h0;
    logic [3:0]  psig, pon, CHAN_OUT, PIN_OUT, PIN_OE;
    logic [2:0]  PIN_LOCATION;
    logic [31:0] WB_DAT_O, r;
    logic        WB_ACK_O, WB_ERR_O, e;
    int          errors, check_count, ch, hits;
    logic [3:0]  seen, pen;

    always #25 CLK_SYS = ~CLK_SYS;

    rcsd_prod_model i_rcsd_prod_model (.clk(CLK_SYS), .nrst(NRST), .want_sig(want_sig), .want_on(want_on),
        .sig(psig), .on(pon));
    rcsd_top i_rcsd_top (.CLK_SYS(CLK_SYS), .NRST(NRST), .WB_CYC_I(wb_req), .WB_STB_I(wb_req), .WB_WE_I(wb_we),
        .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .WB_ERR_O(WB_ERR_O), .PRODUCER_SIG(psig), .PRODUCER_ON(pon), .CHAN_OUT(CHAN_OUT),
        .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_LOCATION(PIN_LOCATION));

    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one classic cycle; the request stands until ack or err is sampled high at a rising edge
    task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        @(posedge CLK_SYS);
        wb_req <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1 && n < 20);
        // data and status are taken at the answer edge, only then is the request dropped
        r = WB_DAT_O;
        e = WB_ERR_O;
        wb_req <= 1'b0;
        if (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1) begin
            errors++;
            $display("BAD %0t no bus answer", $time);
            report_and_stop();
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // count cycles where the outputs leave the held pattern
    task automatic watch(input logic [3:0] base);
        hits = 0;
        seen = 4'h0;
        repeat (4) begin
            @(negedge CLK_SYS);
            if (CHAN_OUT !== base) begin
                hits++;
                seen = CHAN_OUT ^ base;
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge CLK_SYS);
        NRST <= 1'b1;
        @(negedge CLK_SYS);
        chk({PIN_LOCATION, PIN_OE, CHAN_OUT}, 32'h0);
        for (ch = 0; ch < 3; ch++) begin
            xfer(1'b0, 4'(ch * 4), 32'h0);
            chk(r, 32'h0);
        end
        xfer(1'b1, RCSD_OFF_HOLD, 32'h0000_000A);
        xfer(1'b0, RCSD_OFF_HOLD, 32'h0);
        chk(r, 32'h0000_000A);
        watch(4'hA);
        chk(32'(hits), 32'h0);
        for (ch = 0; ch < 4; ch++) begin
            xfer(1'b1, RCSD_OFF_PULSE, 32'h1 << ch);
            watch(4'hA);
            chk(32'(hits), 32'h1);
            chk(seen, 4'h1 << ch);
        end
        xfer(1'b1, RCSD_OFF_PULSE, 32'h0);
        watch(4'hA);
        chk(32'(hits), 32'h0);
        xfer(1'b0, RCSD_OFF_PULSE, 32'h0);
        chk(r, 32'h0);
        want_on  <= 4'h5;
        want_sig <= 4'h3;
        // the producer model and the channel flop each add one edge
        repeat (2) @(posedge CLK_SYS);
        watch(4'hB);
        chk(32'(hits), 32'h0);
        for (ch = 0; ch < 3; ch++) begin
            pen = 4'hF >> ch;
            xfer(1'b1, RCSD_OFF_ROUTE, {21'h0, 3'(ch), 4'h0, pen});
            xfer(1'b0, RCSD_OFF_ROUTE, 32'h0);
            chk(r, {21'h0, 3'(ch), 4'h0, pen});
            @(negedge CLK_SYS);
            chk({PIN_LOCATION, PIN_OE}, {3'(ch), pen});
            chk(PIN_OUT & pen, CHAN_OUT & pen);
        end
        // a level write without byte lane 0 is ignored
        @(posedge CLK_SYS);
        wb_sel <= 4'hE;
        xfer(1'b1, RCSD_OFF_HOLD, 32'h0000_0005);
        wb_sel <= 4'hF;
        xfer(1'b0, RCSD_OFF_HOLD, 32'h0);
        chk(r, 32'h0000_000A);
        xfer(1'b0, 4'hC, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        // second reset in mid-run must clear the stored level and pin enables
        @(posedge CLK_SYS);
        NRST <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        NRST <= 1'b1;
        xfer(1'b0, RCSD_OFF_HOLD, 32'h0);
        chk(r, 32'h0);
        chk({PIN_LOCATION, PIN_OE}, 32'h0);
        report_and_stop();
    end
endmodule
